// *** ilim_pkg.sv ***
// Notes on behaviour
// [R1] Direct mode: input sets frequency, off-time from code
// [R2] Controller keeps off-time at least input period
// [R3] Current mode limiting: off-time alone sets frequency
// [R4] Each PWM cycle starts with bridge driving
// [R5] Over threshold: recirculate for off-time, chosen path
// [R6] Current mode: duty top four bits set threshold
// [R7] Other modes: threshold is (n+1) times 12.5 mV
// [R8] Recirculation code selects auto, high, low, fast
// [R9] Off-time 20 us plus n times 1.6 us
// [R10] Indirect and speed modes: fixed period equals off-time
// [R11] Comparator ignored n times 400 ns after turn-on
// [R12] Same blanking masks drain-source short monitors
// [R13] Controller programs blanking long enough for transients
// [R14] Fault output open-drain, low while faults reported
// [R15] Direct mode: fault low while present or latched
// [R16] Indirect modes: steady low only for stopping faults
// [R17] Pulse low rest of period plus 2/3/4 periods
// [R18] Repeating pulses: equal inactive gap, then repeat
// [R19] Fault line may drive input; input clears latch
// [R20] Stop-on-fault short latch cleared by 0%, read, reset
// [R21] Indirect warning with stop: four low, four off
// [R22] Duty measured from high count over period count
package ilim_pkg;
	localparam int CLK_MHZ = 250;
	localparam int OFF_BASE_NS = 20000;
	localparam int OFF_STEP_NS = 1600;
	localparam int BLANK_STEP_NS = 400;
	localparam int OFF_BASE_CYC = OFF_BASE_NS * CLK_MHZ / 1000;
	localparam int OFF_STEP_CYC = OFF_STEP_NS * CLK_MHZ / 1000;
	localparam int BLANK_STEP_CYC = BLANK_STEP_NS * CLK_MHZ / 1000;
	localparam int CNT_W = 16;
	localparam int DUTY_W = 8;
	localparam logic [1:0] RECIRC_AUTO = 2'h0;
	localparam logic [1:0] RECIRC_HIGH = 2'h1;
	localparam logic [1:0] RECIRC_LOW = 2'h2;
	localparam logic [1:0] RECIRC_FAST = 2'h3;
	localparam logic [1:0] RECIRC_RESET = RECIRC_AUTO;
	localparam logic [3:0] THRESH_RESET = 4'h0;
	typedef enum logic [1:0] {
		MODE_DIRECT_DUTY,
		MODE_INDIRECT_DUTY,
		MODE_SPEED,
		MODE_CURRENT
	} ctrl_mode_t;
	typedef enum logic [1:0] {
		GRP_NONE,
		GRP_TWO,
		GRP_THREE,
		GRP_FOUR
	} fault_group_t;
	function automatic logic [CNT_W-1:0] off_cycles(input logic [4:0] code);
		off_cycles = CNT_W'(OFF_BASE_CYC) + CNT_W'(OFF_STEP_CYC) * CNT_W'(code);
	endfunction
	function automatic logic [2:0] group_periods(input logic [1:0] grp);
		case (grp)
			2'h1: group_periods = 3'h2;
			2'h2: group_periods = 3'h3;
			default: group_periods = 3'h4;
		endcase
	endfunction
endpackage

// *** duty_meter.sv ***
`timescale 1ns/1ps
`default_nettype none
module duty_meter
	import ilim_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Input and result
	input wire logic pwm_in,
	output logic [DUTY_W-1:0] duty,
	output logic period_start,
	output logic zero_duty
);
	logic pwm_q;
	logic [CNT_W-1:0] high_cnt;
	logic [CNT_W-1:0] per_cnt;
	logic [CNT_W-1:0] low_run;
	logic [CNT_W+DUTY_W-1:0] scaled;
	logic rise;

	assign rise = pwm_in && !pwm_q;
	assign scaled = {high_cnt, {DUTY_W{1'b0}}} - {{DUTY_W{1'b0}}, high_cnt};

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pwm_q <= 1'b0;
			high_cnt <= '0;
			per_cnt <= '0;
			duty <= '0;
			period_start <= 1'b0;
		end else begin
			pwm_q <= pwm_in;
			period_start <= rise;
			if (rise) begin
				// Ratio of high count to period, 255 full scale
				if (per_cnt != '0)
					duty <= DUTY_W'(scaled / (CNT_W+DUTY_W)'(per_cnt)); // R22
				high_cnt <= 16'h0001;
				per_cnt <= 16'h0001;
			end else begin
				if (per_cnt != '1)
					per_cnt <= per_cnt + 16'h0001;
				if (pwm_in && high_cnt != '1)
					high_cnt <= high_cnt + 16'h0001;
			end
		end
	end

	// Input held low for a full counter span counts as 0% duty
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			low_run <= '0;
			zero_duty <= 1'b0;
		end else begin
			low_run <= pwm_in ? '0 : (low_run == '1 ? low_run : low_run + 16'h0001);
			zero_duty <= (low_run == '1) && !pwm_in; // R20
		end
	end
endmodule // duty_meter
`default_nettype wire

// *** ilim_ctrl.sv ***
`timescale 1ns/1ps
`default_nettype none
module ilim_ctrl
	import ilim_pkg::*;
(
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Configuration
	input wire logic [1:0] ctrl_mode,
	input wire logic [4:0] off_time_code,
	input wire logic [3:0] limit_threshold_code,
	input wire logic [1:0] recirc_select,
	input wire logic [3:0] blank_time_code,
	input wire logic stop_on_fault_enable,
	// Control input and sensing
	input wire logic pwm_in,
	input wire logic ilim_cmp,
	input wire logic ds_short_raw,
	input wire logic bemf_rising,
	// Fault sources
	input wire logic fault_stop,
	input wire logic fault_sync_lost,
	input wire logic fault_short,
	input wire logic fault_overtemp,
	input wire logic fault_temp_warn,
	input wire logic serial_read_done,
	// Bridge control
	output logic bridge_drive,
	output logic recirc_high,
	output logic recirc_low,
	output logic recirc_fast,
	output logic gate_disable,
	output logic [3:0] current_limit_threshold,
	output logic ds_short_masked,
	// Fault pin
	output logic fault_out_n,
	output logic fault_oe
);
	logic [DUTY_W-1:0] duty;
	logic period_start;
	logic zero_duty;
	logic direct;
	logic [CNT_W-1:0] off_or_period_time;
	logic [CNT_W-1:0] off_cnt;
	logic [CNT_W-1:0] per_cnt;
	logic [CNT_W-1:0] blanking_time;
	logic [CNT_W-1:0] blank_cnt;
	logic in_recirc;
	logic blanked;
	logic cycle_start;
	logic short_latched;
	logic [1:0] group;
	logic repeat_seq;
	logic steady_low;
	logic pulse_active;
	logic pulse_low;
	logic [2:0] per_left;
	logic phase_gap;
	logic pulse_hold;
	logic [3:0] next_threshold;
	logic pwm_q;

	duty_meter u_duty (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.pwm_in(pwm_in),
		.duty(duty),
		.period_start(period_start),
		.zero_duty(zero_duty)
	);

	assign direct = (ctrl_mode == 2'(MODE_DIRECT_DUTY));
	assign off_or_period_time = off_cycles(off_time_code); // R9
	assign blanking_time = CNT_W'(BLANK_STEP_CYC) * CNT_W'(blank_time_code); // R11
	assign blanked = (blank_cnt != '0);

	// ---------------------------------------------------------------
	// Threshold selection
	// ---------------------------------------------------------------
	always_comb begin
		if (ctrl_mode == 2'(MODE_CURRENT))
			next_threshold = duty[DUTY_W-1 -: 4]; // R6
		else
			next_threshold = limit_threshold_code; // R7
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			current_limit_threshold <= THRESH_RESET;
		else
			current_limit_threshold <= next_threshold;
	end

	// ---------------------------------------------------------------
	// PWM cycle start
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			pwm_q <= 1'b0;
		else
			pwm_q <= pwm_in;
	end

	// Fixed period in indirect and speed modes
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			per_cnt <= '0;
		else if (direct || ctrl_mode == 2'(MODE_CURRENT))
			per_cnt <= '0;
		else if (per_cnt >= off_or_period_time - 16'h0001)
			per_cnt <= '0; // R10
		else
			per_cnt <= per_cnt + 16'h0001;
	end

	always_comb begin
		case (ctrl_mode)
			2'(MODE_DIRECT_DUTY): cycle_start = pwm_in && !pwm_q; // R1
			2'(MODE_CURRENT): cycle_start = !in_recirc && !bridge_drive; // R3
			default: cycle_start = (per_cnt == '0); // R10
		endcase
	end

	// ---------------------------------------------------------------
	// Drive and recirculation
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			bridge_drive <= 1'b0;
			in_recirc <= 1'b0;
			off_cnt <= '0;
		end else if (gate_disable) begin
			bridge_drive <= 1'b0;
			in_recirc <= 1'b0;
			off_cnt <= '0;
		end else if (in_recirc) begin
			if (off_cnt <= 16'h0001) begin
				in_recirc <= 1'b0; // R5
				off_cnt <= '0;
			end else
				off_cnt <= off_cnt - 16'h0001;
		end else if (bridge_drive && ilim_cmp && !blanked) begin
			bridge_drive <= 1'b0; // R5
			in_recirc <= 1'b1;
			off_cnt <= off_or_period_time; // R1 R3 R10
		end else if (cycle_start && !bridge_drive) begin
			bridge_drive <= 1'b1; // R4
		end
	end

	// Blank timer restarts on each turn-on
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			blank_cnt <= '0;
		else if (cycle_start && !bridge_drive && !in_recirc && !gate_disable)
			blank_cnt <= blanking_time; // R11
		else if (blanked)
			blank_cnt <= blank_cnt - 16'h0001;
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			ds_short_masked <= 1'b0;
		else
			ds_short_masked <= ds_short_raw && !blanked; // R12
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			recirc_high <= 1'b0;
			recirc_low <= 1'b0;
			recirc_fast <= 1'b0;
		end else begin
			recirc_high <= 1'b0;
			recirc_low <= 1'b0;
			recirc_fast <= 1'b0;
			if (in_recirc) begin
				case (recirc_select) // R8
					RECIRC_HIGH: recirc_high <= 1'b1;
					RECIRC_LOW: recirc_low <= 1'b1;
					RECIRC_FAST: recirc_fast <= 1'b1;
					default: begin
						recirc_high <= bemf_rising;
						recirc_low <= !bemf_rising;
					end
				endcase
			end
		end
	end

	// ---------------------------------------------------------------
	// Short latch and gate disable
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			short_latched <= 1'b0;
		else if (fault_short && stop_on_fault_enable)
			short_latched <= 1'b1; // R20
		else if (zero_duty || serial_read_done)
			short_latched <= 1'b0; // R19 R20
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n)
			gate_disable <= 1'b0;
		else
			gate_disable <= fault_stop || short_latched ||
				(stop_on_fault_enable && (fault_sync_lost || fault_overtemp));
	end

	// ---------------------------------------------------------------
	// Fault classification
	// ---------------------------------------------------------------
	always_comb begin
		steady_low = 1'b0;
		group = 2'(GRP_NONE);
		repeat_seq = 1'b0;
		if (direct) begin
			steady_low = fault_stop || fault_sync_lost || fault_short || short_latched ||
				fault_overtemp || fault_temp_warn; // R15
		end else begin
			steady_low = fault_stop || (fault_overtemp && stop_on_fault_enable); // R16
			if (fault_short || short_latched) begin
				group = 2'(GRP_TWO);
				repeat_seq = stop_on_fault_enable;
			end else if (fault_sync_lost) begin
				group = 2'(GRP_THREE);
				repeat_seq = 1'b1;
			end else if (fault_overtemp && !stop_on_fault_enable) begin
				group = 2'(GRP_FOUR);
				repeat_seq = 1'b1;
			end else if (fault_temp_warn && stop_on_fault_enable) begin
				group = 2'(GRP_FOUR); // R21
				repeat_seq = 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// Pulse sequencer counted in input periods
	// ---------------------------------------------------------------
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			pulse_active <= 1'b0;
			pulse_low <= 1'b0;
			phase_gap <= 1'b0;
			pulse_hold <= 1'b0;
			per_left <= 3'h0;
		end else if (!pulse_active) begin
			if (group != 2'(GRP_NONE)) begin
				pulse_active <= 1'b1; // R17
				pulse_low <= 1'b1;
				phase_gap <= 1'b0;
				per_left <= group_periods(group);
			end
		end else if (pulse_hold) begin
			// Single pulse spent: stay released until the fault clears
			if (group == 2'(GRP_NONE)) begin
				pulse_active <= 1'b0; // R17
				pulse_hold <= 1'b0;
			end
		end else if (period_start) begin
			if (per_left != 3'h0) begin
				per_left <= per_left - 3'h1;
			end else if (!phase_gap && repeat_seq) begin
				pulse_low <= 1'b0; // R18
				phase_gap <= 1'b1;
				per_left <= group_periods(group) - 3'h1;
			end else if (phase_gap && group != 2'(GRP_NONE)) begin
				pulse_low <= 1'b1; // R18
				phase_gap <= 1'b0;
				per_left <= group_periods(group) - 3'h1;
			end else begin
				pulse_low <= 1'b0;
				phase_gap <= 1'b0;
				if (group == 2'(GRP_NONE))
					pulse_active <= 1'b0;
				else
					pulse_hold <= 1'b1; // R17
			end
		end
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			fault_out_n <= 1'b1;
			fault_oe <= 1'b0;
		end else begin
			fault_out_n <= !(steady_low || pulse_low); // R14
			fault_oe <= steady_low || pulse_low; // R14 R19
		end
	end

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	AST_THRESH_CURRENT: assert property (@(posedge clk_sys) disable iff (!rst_n) // R6
		ctrl_mode == 2'(MODE_CURRENT) |=> current_limit_threshold == $past(duty[7:4]))
		else $error("threshold not from duty");
	AST_THRESH_CODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R7
		ctrl_mode != 2'(MODE_CURRENT) |=> current_limit_threshold == $past(limit_threshold_code))
		else $error("threshold not from code");
	AST_TRIP_RECIRC: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
		bridge_drive && ilim_cmp && !blanked && !in_recirc && !gate_disable
		|=> in_recirc && !bridge_drive && off_cnt == $past(off_or_period_time))
		else $error("trip did not start off-time");
	AST_BLANK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R11
		bridge_drive && blanked && !in_recirc && !gate_disable |=> !in_recirc)
		else $error("comparator acted during blanking");
	AST_DS_MASK: assert property (@(posedge clk_sys) disable iff (!rst_n) // R12
		blanked |=> !ds_short_masked)
		else $error("short monitor not masked");
	AST_FAST_MODE: assert property (@(posedge clk_sys) disable iff (!rst_n) // R8
		in_recirc && recirc_select == RECIRC_FAST |=> recirc_fast && !recirc_high && !recirc_low)
		else $error("wrong recirculation path");
	AST_PIN_OD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R14
		fault_oe != fault_out_n)
		else $error("fault pin not open-drain");
	AST_DIRECT_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n) // R15
		direct && fault_short |=> fault_oe)
		else $error("direct fault not low");
	AST_SHORT_LATCH: assert property (@(posedge clk_sys) disable iff (!rst_n) // R20
		short_latched && !zero_duty && !serial_read_done |=> ##1 gate_disable)
		else $error("gates not held off");
	AST_PULSE_START: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
		!pulse_active && group != 2'(GRP_NONE) |=> pulse_low ##1 fault_oe)
		else $error("pulse did not start");
	AST_PULSE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n) // R17
		pulse_hold && !steady_low |=> !fault_oe)
		else $error("single pulse repeated");
	AST_TURN_ON: assert property (@(posedge clk_sys) disable iff (!rst_n) // R4
		cycle_start && !bridge_drive && !in_recirc && !gate_disable |=> bridge_drive)
		else $error("bridge not driven at cycle start");
	AST_RECIRC_END: assert property (@(posedge clk_sys) disable iff (!rst_n) // R5
		in_recirc && off_cnt <= 16'h0001 && !gate_disable |=> !in_recirc)
		else $error("off-time overran");
	AST_GATE_OFF: assert property (@(posedge clk_sys) disable iff (!rst_n) // R20
		gate_disable |=> !bridge_drive && !in_recirc)
		else $error("bridge active while gates disabled");
	AST_STEADY: assert property (@(posedge clk_sys) disable iff (!rst_n) // R16
		!direct && fault_stop |=> fault_oe)
		else $error("stopping fault not held low");
endmodule // ilim_ctrl
`default_nettype wire

// *** ecu_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module ecu_model (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Waveform setting
	input wire logic [15:0] period,
	input wire logic [15:0] high,
	// Lines
	input wire logic fault_line,
	output logic pwm_in,
	output logic [15:0] fault_reports
);
	logic [15:0] cnt;
	logic line_d;
	// ----------
	// Control waveform, kept running while faults are reported
	// ----------
	always @(posedge clk_sys) begin
		#1;
		if (!rst_n || cnt >= period - 16'h0001) begin
			cnt = 16'h0000;
		end else begin
			cnt = cnt + 16'h0001;
		end
		pwm_in = rst_n && (cnt < high);
	end
	// ----------
	// Count falling edges seen on the fault line
	// ----------
	always @(posedge clk_sys) begin
		line_d <= fault_line;
		if (!rst_n) begin
			fault_reports <= 16'h0000;
		end else if (line_d && !fault_line) begin
			fault_reports <= fault_reports + 16'h0001;
		end
	end
endmodule // ecu_model
`default_nettype wire

// *** tb_bldc_current_limit_fault_pulse.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb_bldc_current_limit_fault_pulse;
	import ilim_pkg::*;
	// ----------
	// Signals
	// ----------
	localparam int FP = 400;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	logic [1:0] ctrl_mode = 2'h0;
	logic [4:0] off_time_code = 5'h00;
	logic [3:0] limit_threshold_code = 4'h0;
	logic [1:0] recirc_select = 2'h0;
	logic [3:0] blank_time_code = 4'h1;
	logic stop_on_fault_enable = 1'b0;
	logic ilim_cmp = 1'b0;
	logic ds_short_raw = 1'b0;
	logic bemf_rising = 1'b0;
	logic [4:0] flt = 5'h00;
	logic serial_read_done = 1'b0;
	logic [15:0] period = 16'h0190;
	logic [15:0] high = 16'h00C8;
	wire logic pwm_in;
	wire logic [15:0] fault_reports;
	wire logic bridge_drive, recirc_high, recirc_low, recirc_fast, gate_disable;
	wire logic ds_short_masked, fault_out_n, fault_oe, fault_line;
	wire logic [3:0] current_limit_threshold;
	int error_cnt = 0;
	int samples_checked = 0;
	int c_idx[8] = '{2, 1, 3, 4, 2, 0, 4, 2};
	int c_esf[8] = '{1, 0, 0, 1, 0, 0, 0, 0};
	int c_n[8] = '{2, 3, 4, 4, 2, 0, 0, 0};
	int c_rep[8] = '{1, 1, 1, 1, 0, 0, 0, 0};
	// Pull-up on the open-drain line
	assign fault_line = fault_oe ? fault_out_n : 1'b1;
	always #2 clk_sys = ~clk_sys;
	ilim_ctrl uut (.clk_sys(clk_sys), .rst_n(rst_n), .ctrl_mode(ctrl_mode),
		.off_time_code(off_time_code), .limit_threshold_code(limit_threshold_code),
		.recirc_select(recirc_select), .blank_time_code(blank_time_code),
		.stop_on_fault_enable(stop_on_fault_enable), .pwm_in(pwm_in), .ilim_cmp(ilim_cmp),
		.ds_short_raw(ds_short_raw), .bemf_rising(bemf_rising), .fault_stop(flt[0]),
		.fault_sync_lost(flt[1]), .fault_short(flt[2]), .fault_overtemp(flt[3]),
		.fault_temp_warn(flt[4]), .serial_read_done(serial_read_done),
		.bridge_drive(bridge_drive), .recirc_high(recirc_high), .recirc_low(recirc_low),
		.recirc_fast(recirc_fast), .gate_disable(gate_disable),
		.current_limit_threshold(current_limit_threshold), .ds_short_masked(ds_short_masked),
		.fault_out_n(fault_out_n), .fault_oe(fault_oe));
	ecu_model u_ecu (.clk_sys(clk_sys), .rst_n(rst_n), .period(period), .high(high),
		.fault_line(fault_line), .pwm_in(pwm_in), .fault_reports(fault_reports));
	// ----------
	// Helpers
	// ----------
	task automatic close_out();
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask
	task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
		samples_checked++;
		if (got !== exp) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s got %0h", $time, what, got);
		end
	endtask
	task automatic chk_rng(input int got, input int lo, input int hi, input string what);
		samples_checked++;
		if (got < lo || got > hi) begin
			error_cnt++;
			$display("MISMATCH at %0t: %s length %0d", $time, what, got);
		end
	endtask
	function automatic logic sig(input int sel);
		if (sel == 0) return fault_line;
		return recirc_high | recirc_low | recirc_fast;
	endfunction
	// Cycles for which the watched line keeps the level
	task automatic span(input int sel, input logic lvl, input int bound, output int n);
		n = 0;
		while (sig(sel) === lvl) begin
			n++;
			if (n > bound) begin
				error_cnt++;
				$display("MISMATCH at %0t: wait limit", $time);
				close_out();
			end
			tick(1);
		end
	endtask
	task automatic do_reset();
		rst_n = 1'b0;
		tick(2);
		rst_n = 1'b1;
	endtask
	function automatic logic [3:0] exp_thr(input int h, input int p);
		return 4'((h * 255 / p) >> 4);
	endfunction
	function automatic logic [3:0] exp_path(input int r, input logic b);
		case (r)
			0: return b ? 4'h8 : 4'h4;
			1: return 4'h8;
			2: return 4'h4;
			default: return 4'h2;
		endcase
	endfunction
	// ----------
	// Sequence
	// ----------
	initial begin
		int n, m, o, b, h, code;
		void'($urandom(27));
		tick(2);
		chk_val({fault_oe, fault_out_n, gate_disable, recirc_high, recirc_low}, 16'h0008, "rst");
		rst_n = 1'b1;
		for (int md = 0; md < 3; md++) begin
			for (int k = 0; k < 2; k++) begin
				ctrl_mode = 2'(md);
				code = (k == 0) ? $urandom_range(0, 14) : 15;
				limit_threshold_code = 4'(code);
				tick(3);
				chk_val(current_limit_threshold, 16'(code), "threshold code");
			end
		end
		ctrl_mode = MODE_CURRENT;
		period = 16'h03E8;
		for (int k = 0; k < 3; k++) begin
			h = $urandom_range(1, 999);
			high = 16'(h);
			tick(2 * 1000 + 10);
			chk_val(current_limit_threshold, exp_thr(h, 1000), "duty threshold");
		end
		ilim_cmp = 1'b1;
		ds_short_raw = 1'b1;
		for (int r = 0; r < 5; r++) begin
			recirc_select = 2'((r == 0) ? 0 : r - 1);
			bemf_rising = (r == 0);
			o = $urandom_range(0, 2);
			b = $urandom_range(2, 6);
			off_time_code = 5'(o);
			blank_time_code = 4'(b);
			span(1, 0, 20000, n);
			span(1, 1, 8000, n);
			chk_rng(n, OFF_BASE_CYC + OFF_STEP_CYC * o - 2, OFF_BASE_CYC + OFF_STEP_CYC * o + 2, "off");
			span(1, 0, 3000, m);
			chk_rng(m, BLANK_STEP_CYC * b, BLANK_STEP_CYC * b + 4, "blank");
			chk_val({recirc_high, recirc_low, recirc_fast, bridge_drive}, exp_path(recirc_select, bemf_rising), "path");
			span(1, 1, 8000, n);
			tick(BLANK_STEP_CYC * b / 2);
			chk_val(bridge_drive, 16'h0001, "drive");
			chk_val(ds_short_masked, 16'h0000, "ds mask");
		end
		ilim_cmp = 1'b0;
		tick(BLANK_STEP_CYC * 15 + 10);
		chk_val(ds_short_masked, 16'h0001, "ds pass");
		ds_short_raw = 1'b0;
		// Fixed-period mode: off-time follows the programmed period
		ctrl_mode = MODE_INDIRECT_DUTY;
		ilim_cmp = 1'b1;
		span(1, 0, 3000, n);
		span(1, 1, 8000, n);
		chk_rng(n, OFF_BASE_CYC + OFF_STEP_CYC * o - 2, OFF_BASE_CYC + OFF_STEP_CYC * o + 2, "fixed off");
		ilim_cmp = 1'b0;
		period = 16'(FP);
		high = 16'h00C8;
		// Fault reporting table
		for (int c = 0; c < 8; c++) begin
			do_reset();
			off_time_code = 5'h1F;
			ctrl_mode = (c >= 6) ? MODE_DIRECT_DUTY : MODE_INDIRECT_DUTY;
			stop_on_fault_enable = c_esf[c][0];
			tick($urandom_range(10, FP - 10));
			flt = 5'h01 << c_idx[c];
			span(0, 1, 10, m);
			chk_rng(m, 1, 3, "onset");
			if (c_n[c] == 0) begin
				tick(3 * FP);
				chk_val(fault_line, 16'h0000, "steady");
				flt = 5'h00;
				tick(4);
				chk_val(fault_line, 16'h0001, "release");
			end else begin
				span(0, 0, 6 * FP, m);
				chk_rng(m, c_n[c] * FP - 4, (c_n[c] + 1) * FP + 4, "pulse");
				if (c_rep[c] == 1) begin
					span(0, 1, 6 * FP, m);
					chk_rng(m, c_n[c] * FP - 4, c_n[c] * FP + 4, "gap");
					span(0, 0, 6 * FP, m);
					chk_rng(m, c_n[c] * FP - 4, c_n[c] * FP + 4, "repeat");
					chk_val(fault_reports, 16'h0002, "reports");
				end else begin
					tick(5 * FP);
					chk_val(fault_line, 16'h0001, "single");
				end
			end
			if (c == 0) begin
				chk_val(gate_disable, 16'h0001, "stop latch");
				flt = 5'h00;
				serial_read_done = 1'b1;
				tick(1);
				serial_read_done = 1'b0;
				tick(4);
				chk_val(gate_disable, 16'h0000, "latch clear");
			end
			flt = 5'h00;
		end
		close_out();
	end
endmodule // tb_bldc_current_limit_fault_pulse
`default_nettype wire
